//--- core/tlic_defines.svh
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

// Special function register addresses seen by the core.
`define TLIC_ADDR_EN_MAIN 8'hA8
`define TLIC_ADDR_PRIO_MAIN 8'hB8
`define TLIC_ADDR_FLAGS 8'hC0
`define TLIC_ADDR_EN_PORT 8'hE8
`define TLIC_ADDR_POLARITY 8'hE9
`define TLIC_ADDR_PRIO_PORT 8'hF8

// Field positions in the main enable register; bits 3..0 also in the main priority register.
`define TLIC_BIT_GATE 7
`define TLIC_BIT_TIMER_ONE 3
`define TLIC_BIT_EXT_ONE 2
`define TLIC_BIT_TIMER_ZERO 1
`define TLIC_BIT_EXT_ZERO 0

// Reset values of every register.
`define TLIC_RST_EN 8'h00
`define TLIC_RST_PRIO 8'h00
`define TLIC_RST_POL 8'h00
`define TLIC_RST_FLAGS 8'h00
`define TLIC_RST_PINS 8'hFF // Port lines rest high on their pull-ups.

// Vector addresses, indexed by position in the fixed service order.
`define TLIC_VEC_0 16'h0003
`define TLIC_VEC_1 16'h0053
`define TLIC_VEC_2 16'h000B
`define TLIC_VEC_3 16'h005B
`define TLIC_VEC_4 16'h0013
`define TLIC_VEC_5 16'h003B
`define TLIC_VEC_6 16'h0063
`define TLIC_VEC_7 16'h001B
`define TLIC_VEC_8 16'h0043
`define TLIC_VEC_9 16'h006B
`define TLIC_VEC_10 16'h004B
`define TLIC_VEC_11 16'h0073

`endif

//--- core/tlic_pkg.sv
package tlic_pkg;
  // One bit per source, in fixed service order, highest first.
  typedef logic [11:0] tlic_src_vec_t;
  // Position of a source in the service order.
  typedef logic [3:0] tlic_src_idx_t;
  // Special function register byte and address.
  typedef logic [7:0] tlic_byte_t;
  // Program address of a service routine.
  typedef logic [15:0] tlic_vec_addr_t;
  // Service level of a routine or request.
  typedef enum logic {TLIC_LVL_LOW, TLIC_LVL_HIGH} tlic_level_t;
endpackage

//--- core/tlic_sync.sv
`timescale 1ns/1ps
`include "tlic_defines.svh"
// Three-stage synchroniser for the port interrupt pins; the output takes a new
// value only once the second and third stages agree, which filters one-cycle glitches.
module tlic_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_sync
);
  import tlic_pkg::*;

  // Stages start at the idle pin level, so an active-low line is not seen as active
  // straight after reset and no flag is set by a false request.
  localparam logic [7:0] pin_idle = `TLIC_RST_PINS;

  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;

  // Plain flop chain; only the second stage reads the first.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= pin_idle;
      s2_q <= pin_idle;
      s3_q <= pin_idle;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Each bit updates on its own when its two late stages agree.
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_bit
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          pin_sync[k] <= pin_idle[k];
        end else if (s2_q[k] == s3_q[k]) begin
          pin_sync[k] <= s3_q[k];
        end
      end
    end
  endgenerate
endmodule // tlic_sync

//--- core/tlic_ctrl.sv
// Operation
// - Twelve sources: external 0 and 1, two timer overflows, port lines 2 to 9.
// - Each source has its own enable bit; cleared bit blocks service.
// - Each source's level comes from its own priority register bit.
// - Port lines are level detected and, when enabled, wake from power-down.
// - Each port line's active level is selected by a polarity bit.
// - Hardware sets port flags on recognition; only software clears them.
// - A flag still set after return raises a fresh interrupt.
// - Main enable bit 7 gates all sources off when cleared.
// - Main enable bits 3..0: timer one, external one, timer zero, external zero.
// - Port enable register bit 7 is line 9 down to bit 0 line 2.
// - Enable bit zero disables, one enables.
// - Main priority bits 3..0 as enables; one selects high level; bit 7 unused.
// - Port priority bit 7 is line 9 down to bit 0 line 2; one high.
// - Polarity zero means active low, one means active high.
// - Port flags live at C0H, line 9 in bit 7 to line 2 in bit 0.
// - Same-level ties resolve in the fixed twelve-entry order.
// - Each source vectors to its fixed program address.
`timescale 1ns/1ps
`include "tlic_defines.svh"
module tlic_ctrl (
  input wire logic mclk,
  input wire logic rst_b,
  input wire tlic_pkg::tlic_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire tlic_pkg::tlic_byte_t sfr_wdata,
  output tlic_pkg::tlic_byte_t sfr_rdata,
  input wire logic ext_zero_req,
  input wire logic ext_one_req,
  input wire logic timer_zero_ovf,
  input wire logic timer_one_ovf,
  input wire logic [7:0] port_int_pins,
  input wire logic int_ack,
  input wire logic int_reti,
  output logic int_req,
  output tlic_pkg::tlic_level_t int_lvl,
  output tlic_pkg::tlic_src_idx_t int_src,
  output tlic_pkg::tlic_vec_addr_t int_vector,
  output logic wake_req
);
  import tlic_pkg::*;

  tlic_byte_t en_main_q;
  tlic_byte_t prio_main_q;
  tlic_byte_t en_port_q;
  tlic_byte_t prio_port_q;
  tlic_byte_t pol_q;
  tlic_byte_t flag_q;
  logic [7:0] pins_s;
  logic [7:0] port_act;
  tlic_src_vec_t req_ord;
  tlic_src_vec_t en_ord;
  tlic_src_vec_t prio_ord;
  tlic_src_vec_t elig_hi;
  tlic_src_vec_t elig_lo;
  tlic_src_vec_t elig_sel;
  tlic_src_vec_t elig_sel_q;
  tlic_src_vec_t en_ord_q;
  tlic_src_vec_t prio_ord_q;
  tlic_src_idx_t win_idx;
  logic win_valid;
  tlic_level_t win_lvl;
  logic in_hi_q;
  logic in_lo_q;
  logic wr_flags;

  // Port pins come from outside the clock domain.
  tlic_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in(port_int_pins),
    .pin_sync(pins_s)
  );

  assign wr_flags = sfr_wr && (sfr_addr == `TLIC_ADDR_FLAGS);

  // Control registers; unused bits are not stored and read back as zero.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_main_q <= `TLIC_RST_EN;
      prio_main_q <= `TLIC_RST_PRIO;
      en_port_q <= `TLIC_RST_EN;
      prio_port_q <= `TLIC_RST_PRIO;
      pol_q <= `TLIC_RST_POL;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `TLIC_ADDR_EN_MAIN: en_main_q <= sfr_wdata & 8'h8F;
        `TLIC_ADDR_PRIO_MAIN: prio_main_q <= sfr_wdata & 8'h0F;
        `TLIC_ADDR_EN_PORT: en_port_q <= sfr_wdata;
        `TLIC_ADDR_PRIO_PORT: prio_port_q <= sfr_wdata;
        `TLIC_ADDR_POLARITY: pol_q <= sfr_wdata;
        default: ;
      endcase
    end
  end

  // Per-line level detection and sticky flag. A write of zero clears a flag,
  // but a line still active in that same cycle sets it again, so no request is lost.
  genvar k;
  generate
    for (k = 0; k < 8; k++) begin : g_line
      assign port_act[k] = ~(pins_s[k] ^ pol_q[k]);
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          flag_q[k] <= 1'b0;
        end else if (port_act[k]) begin
          flag_q[k] <= 1'b1;
        end else if (wr_flags && !sfr_wdata[k]) begin
          flag_q[k] <= 1'b0;
        end
      end
    end
  endgenerate

  // Wake must work with the clock stopped, so it looks at the raw pins.
  assign wake_req = |(~(port_int_pins ^ pol_q) & en_port_q);

  // Sources, enables and levels in fixed service order, highest in bit 0.
  assign req_ord = {flag_q[7], flag_q[2], flag_q[6], flag_q[1], timer_one_ovf, flag_q[5],
                    flag_q[0], ext_one_req, flag_q[4], timer_zero_ovf, flag_q[3], ext_zero_req};
  assign en_ord = {en_port_q[7], en_port_q[2], en_port_q[6], en_port_q[1],
                   en_main_q[`TLIC_BIT_TIMER_ONE], en_port_q[5], en_port_q[0],
                   en_main_q[`TLIC_BIT_EXT_ONE], en_port_q[4],
                   en_main_q[`TLIC_BIT_TIMER_ZERO], en_port_q[3], en_main_q[`TLIC_BIT_EXT_ZERO]};
  assign prio_ord = {prio_port_q[7], prio_port_q[2], prio_port_q[6], prio_port_q[1],
                     prio_main_q[`TLIC_BIT_TIMER_ONE], prio_port_q[5], prio_port_q[0],
                     prio_main_q[`TLIC_BIT_EXT_ONE], prio_port_q[4],
                     prio_main_q[`TLIC_BIT_TIMER_ZERO], prio_port_q[3],
                     prio_main_q[`TLIC_BIT_EXT_ZERO]};

  // Eligibility: a high routine blocks all, a low routine blocks other lows.
  always_comb begin
    elig_hi = '0;
    elig_lo = '0;
    if (en_main_q[`TLIC_BIT_GATE]) begin
      elig_hi = req_ord & en_ord & prio_ord;
      elig_lo = req_ord & en_ord & ~prio_ord;
    end
    if (in_hi_q) begin
      elig_hi = '0;
    end
    if (in_hi_q || in_lo_q) begin
      elig_lo = '0;
    end
    elig_sel = (elig_hi != '0) ? elig_hi : elig_lo;
    win_lvl = (elig_hi != '0) ? TLIC_LVL_HIGH : TLIC_LVL_LOW;
  end

  // First set bit of the chosen level wins the tie.
  always_comb begin
    win_idx = '0;
    win_valid = 1'b0;
    for (int i = 11; i >= 0; i--) begin
      if (elig_sel[i]) begin
        win_idx = 4'(i);
        win_valid = 1'b1;
      end
    end
  end

  // Request towards the core. It drops for one cycle on acceptance so the
  // in-service state is in place before the next decision.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_req <= 1'b0;
      int_lvl <= TLIC_LVL_LOW;
      int_src <= '0;
      int_vector <= '0;
    end else begin
      int_req <= win_valid && !int_ack && !int_reti;
      int_lvl <= win_lvl;
      int_src <= win_idx;
      case (win_idx)
        4'h0: int_vector <= `TLIC_VEC_0;
        4'h1: int_vector <= `TLIC_VEC_1;
        4'h2: int_vector <= `TLIC_VEC_2;
        4'h3: int_vector <= `TLIC_VEC_3;
        4'h4: int_vector <= `TLIC_VEC_4;
        4'h5: int_vector <= `TLIC_VEC_5;
        4'h6: int_vector <= `TLIC_VEC_6;
        4'h7: int_vector <= `TLIC_VEC_7;
        4'h8: int_vector <= `TLIC_VEC_8;
        4'h9: int_vector <= `TLIC_VEC_9;
        4'hA: int_vector <= `TLIC_VEC_10;
        default: int_vector <= `TLIC_VEC_11;
      endcase
    end
  end

  // Two-deep service stack: acceptance pushes the level, return pops the highest.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      in_hi_q <= 1'b0;
      in_lo_q <= 1'b0;
    end else if (int_ack && int_req) begin
      if (int_lvl == TLIC_LVL_HIGH) begin
        in_hi_q <= 1'b1;
      end else begin
        in_lo_q <= 1'b1;
      end
    end else if (int_reti) begin
      if (in_hi_q) begin
        in_hi_q <= 1'b0;
      end else begin
        in_lo_q <= 1'b0;
      end
    end
  end

  // Read data is registered: it answers one cycle after the address.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rdata <= 8'h00;
    end else begin
      case (sfr_addr)
        `TLIC_ADDR_EN_MAIN: sfr_rdata <= en_main_q;
        `TLIC_ADDR_PRIO_MAIN: sfr_rdata <= prio_main_q;
        `TLIC_ADDR_EN_PORT: sfr_rdata <= en_port_q;
        `TLIC_ADDR_PRIO_PORT: sfr_rdata <= prio_port_q;
        `TLIC_ADDR_POLARITY: sfr_rdata <= pol_q;
        `TLIC_ADDR_FLAGS: sfr_rdata <= flag_q;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

  // Delayed copies used only by the checks below.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      elig_sel_q <= '0;
      en_ord_q <= '0;
      prio_ord_q <= '0;
    end else begin
      elig_sel_q <= elig_sel;
      en_ord_q <= en_ord;
      prio_ord_q <= prio_ord;
    end
  end

  gate_blocks_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !en_main_q[`TLIC_BIT_GATE] |=> !int_req)
    else $error("request raised while global gate closed");

  flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !wr_flags |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("port flag cleared without a software write");

  flag_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    port_act != 8'h00 |=> ((flag_q & $past(port_act)) == $past(port_act)))
    else $error("active port line did not set its flag");

  high_blocks_a: assert property (@(posedge mclk) disable iff (!rst_b)
    in_hi_q |-> !int_req)
    else $error("request raised during a high level routine");

  low_preempt_a: assert property (@(posedge mclk) disable iff (!rst_b)
    in_lo_q && int_req |-> int_lvl == TLIC_LVL_HIGH)
    else $error("low request preempted a low routine");

  tie_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_req |-> elig_sel_q[int_src] && ((elig_sel_q & ((12'h001 << int_src) - 12'h001)) == 12'h000))
    else $error("winner is not first in service order");

  vector_map_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_req && int_src == 4'h5 |-> int_vector == `TLIC_VEC_5)
    else $error("port line two vector wrong");

  enable_used_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_req |-> en_ord_q[int_src])
    else $error("disabled source requested");

  level_used_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_req |-> int_lvl == tlic_level_t'(prio_ord_q[int_src]))
    else $error("request level does not match priority bit");

  redo_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_reti && !in_hi_q && in_lo_q && en_main_q[7] && (flag_q[0] & en_port_q[0]) && !wr_flags
    ##1 !wr_flags |=> int_req)
    else $error("uncleared flag did not request again");

  // Acceptance must drop the request for one cycle, or the core could take it twice.
  ack_drop_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_ack && int_req |=> !int_req)
    else $error("request still raised after acceptance");

  // With every line inactive, a flag write leaves only the flags written as one.
  flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_flags && port_act == 8'h00 |=> flag_q == ($past(flag_q) & $past(sfr_wdata)))
    else $error("software write did not clear port flags");

  wake_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    en_port_q == 8'h00 |-> !wake_req)
    else $error("wake raised with every port line disabled");

  vector_t1_a: assert property (@(posedge mclk) disable iff (!rst_b)
    int_req && int_src == 4'h7 |-> int_vector == `TLIC_VEC_7)
    else $error("timer one vector wrong");

  nest_c: cover property (@(posedge mclk) disable iff (!rst_b) in_lo_q && in_hi_q);
  port_c: cover property (@(posedge mclk) disable iff (!rst_b) int_req && int_src == 4'hB);
  wake_c: cover property (@(posedge mclk) disable iff (!rst_b) wake_req && !en_main_q[7]);
  // A return with the flag still set, and a high request waiting over a low routine.
  redo_c: cover property (@(posedge mclk) disable iff (!rst_b) int_reti ##2 int_req);
  preempt_c: cover property (@(posedge mclk) disable iff (!rst_b)
    in_lo_q && int_req && int_lvl == TLIC_LVL_HIGH);
endmodule // tlic_ctrl

//--- sim/tlic_core_model.sv
`timescale 1ns/1ps
// Processor core stand-in: accepts a pending request after a fixed delay and returns on command.
module tlic_core_model #(
  parameter int DLY = 6
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic int_req,
  input wire logic auto_ack,
  input wire logic ret_go,
  output logic int_ack,
  output logic int_reti
);
  int cnt;

  // The delay gives the bench a window to look at a request before it is taken.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      int_ack <= 1'b0;
      int_reti <= 1'b0;
    end else begin
      int_ack <= 1'b0;
      int_reti <= ret_go;
      if (int_req && auto_ack && !int_ack) begin
        cnt <= cnt + 1;
        if (cnt == DLY) begin
          int_ack <= 1'b1;
          cnt <= 0;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule // tlic_core_model

//--- sim/tlic_ctrl_tb.sv
`timescale 1ns/1ps
`include "tlic_defines.svh"
module tlic_ctrl_tb;
  import tlic_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  tlic_byte_t sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  tlic_byte_t sfr_wdata = 8'h00;
  tlic_byte_t sfr_rdata;
  logic ext_zero_req = 1'b0;
  logic ext_one_req = 1'b0;
  logic timer_zero_ovf = 1'b0;
  logic timer_one_ovf = 1'b0;
  logic [7:0] port_int_pins = 8'hFF;
  logic int_ack, int_reti, int_req, wake_req;
  tlic_level_t int_lvl;
  tlic_src_idx_t int_src;
  tlic_vec_addr_t int_vector;
  logic auto_ack = 1'b0;
  logic ret_go = 1'b0;
  int n_fail = 0;
  int checks_done = 0;

  // Half period of 20 ns gives the 25 MHz system clock.
  always #20 mclk = ~mclk;

  tlic_ctrl u_tlic_ctrl (.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .ext_zero_req(ext_zero_req), .ext_one_req(ext_one_req),
    .timer_zero_ovf(timer_zero_ovf), .timer_one_ovf(timer_one_ovf), .port_int_pins(port_int_pins),
    .int_ack(int_ack), .int_reti(int_reti), .int_req(int_req), .int_lvl(int_lvl), .int_src(int_src),
    .int_vector(int_vector), .wake_req(wake_req));

  tlic_core_model u_tlic_core_model (.mclk(mclk), .rst_b(rst_b), .int_req(int_req), .auto_ack(auto_ack),
    .ret_go(ret_go), .int_ack(int_ack), .int_reti(int_reti));

  task automatic stop_test();
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request compare packs pending, level and source index into one word; wake is expected low unless given.
  task automatic chk_req(input logic r, input logic l, input logic [3:0] s, input logic [15:0] v,
    input logic w = 1'b0);
    chk({15'h0000, wake_req}, {15'h0000, w});
    chk({10'h000, int_req, int_lvl, int_src}, {10'h000, r, l, s});
    if (r) chk(int_vector, v);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input tlic_byte_t a, input tlic_byte_t d);
    @(posedge mclk);
    sfr_addr <= a;
    sfr_wr <= 1'b1;
    sfr_wdata <= d;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask

  // Read data is registered, so it is looked at one edge after the address was taken.
  task automatic rd(input tlic_byte_t a, input tlic_byte_t exp);
    @(posedge mclk);
    sfr_addr <= a;
    tick(2);
    chk({8'h00, sfr_rdata}, {8'h00, exp});
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`TLIC_ADDR_EN_MAIN, 8'h00);
    rd(`TLIC_ADDR_PRIO_MAIN, 8'h00);
    rd(`TLIC_ADDR_EN_PORT, 8'h00);
    rd(`TLIC_ADDR_PRIO_PORT, 8'h00);
    rd(`TLIC_ADDR_FLAGS, 8'h00);
    rd(8'h55, 8'h00);
    wr(`TLIC_ADDR_EN_MAIN, 8'hFF);
    rd(`TLIC_ADDR_EN_MAIN, 8'h8F);
    wr(`TLIC_ADDR_PRIO_MAIN, 8'hFF);
    rd(`TLIC_ADDR_PRIO_MAIN, 8'h0F);
    wr(`TLIC_ADDR_EN_PORT, 8'hA5);
    rd(`TLIC_ADDR_EN_PORT, 8'hA5);
    wr(`TLIC_ADDR_PRIO_PORT, 8'h5A);
    rd(`TLIC_ADDR_PRIO_PORT, 8'h5A);
    wr(`TLIC_ADDR_PRIO_PORT, 8'h00);
    wr(`TLIC_ADDR_EN_PORT, 8'h00);
    wr(`TLIC_ADDR_PRIO_MAIN, 8'h00);
    // All four main sources at once; the tie and the level choice decide.
    wr(`TLIC_ADDR_EN_MAIN, 8'h0F);
    ext_zero_req <= 1'b1;
    ext_one_req <= 1'b1;
    timer_zero_ovf <= 1'b1;
    timer_one_ovf <= 1'b1;
    tick(4);
    chk_req(1'b0, 1'b0, 4'h0, 16'h0000);
    wr(`TLIC_ADDR_EN_MAIN, 8'h8F);
    tick(3);
    chk_req(1'b1, 1'b0, 4'h0, 16'h0003);
    wr(`TLIC_ADDR_PRIO_MAIN, 8'h08);
    tick(3);
    chk_req(1'b1, 1'b1, 4'h7, 16'h001B);
    wr(`TLIC_ADDR_PRIO_MAIN, 8'h04);
    tick(3);
    chk_req(1'b1, 1'b1, 4'h4, 16'h0013);
    wr(`TLIC_ADDR_EN_MAIN, 8'h8A);
    wr(`TLIC_ADDR_PRIO_MAIN, 8'h00);
    tick(3);
    chk_req(1'b1, 1'b0, 4'h2, 16'h000B);
    // Low routine taken, then a high request preempts it, then nesting stops at two.
    ext_one_req <= 1'b0;
    timer_one_ovf <= 1'b0;
    wr(`TLIC_ADDR_EN_MAIN, 8'h81);
    auto_ack <= 1'b1;
    tick(12);
    chk_req(1'b0, 1'b0, 4'h0, 16'h0000);
    wr(`TLIC_ADDR_EN_MAIN, 8'h83);
    wr(`TLIC_ADDR_PRIO_MAIN, 8'h02);
    tick(3);
    chk_req(1'b1, 1'b1, 4'h2, 16'h000B);
    tick(12);
    chk_req(1'b0, 1'b0, 4'h0, 16'h0000);
    auto_ack <= 1'b0;
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    tick(4);
    chk_req(1'b1, 1'b1, 4'h2, 16'h000B);
    ext_zero_req <= 1'b0;
    timer_zero_ovf <= 1'b0;
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    // Port line two: idle high pins are inactive at polarity zero, active at polarity one.
    wr(`TLIC_ADDR_EN_MAIN, 8'h80);
    wr(`TLIC_ADDR_EN_PORT, 8'h01);
    tick(3);
    chk({15'h0000, wake_req}, 16'h0000);
    wr(`TLIC_ADDR_POLARITY, 8'h01);
    #1;
    chk({15'h0000, wake_req}, 16'h0001);
    tick(8);
    rd(`TLIC_ADDR_FLAGS, 8'h01);
    chk_req(1'b1, 1'b0, 4'h5, 16'h003B, 1'b1);
    // Take line two as a low routine, then return with its flag still set.
    auto_ack <= 1'b1;
    tick(12);
    chk_req(1'b0, 1'b0, 4'h0, 16'h0000, 1'b1);
    auto_ack <= 1'b0;
    ret_go <= 1'b1;
    @(posedge mclk);
    ret_go <= 1'b0;
    tick(3);
    chk_req(1'b1, 1'b0, 4'h5, 16'h003B, 1'b1);
    wr(`TLIC_ADDR_FLAGS, 8'h00);
    rd(`TLIC_ADDR_FLAGS, 8'h01);
    wr(`TLIC_ADDR_POLARITY, 8'h00);
    tick(8);
    rd(`TLIC_ADDR_FLAGS, 8'h01);
    wr(`TLIC_ADDR_FLAGS, 8'h00);
    rd(`TLIC_ADDR_FLAGS, 8'h00);
    tick(2);
    chk_req(1'b0, 1'b0, 4'h0, 16'h0000);
    stop_test();
  end
endmodule // tlic_ctrl_tb
